// file: design/irq_enable_rank_regs.sv
// interrupt enable and priority registers with request gating and selection
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module irq_enable_rank_regs
  import irq_regs_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [irq_regs_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [irq_regs_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [irq_regs_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [irq_regs_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              ext_a_request_input_n,
  input  wire logic                              ext_b_request_input_n,
  input  wire logic                              timer_a_overflow_flag,
  input  wire logic                              timer_b_overflow_flag,
  input  wire logic                              serial_pending,
  input  wire logic                              usb_pending,
  input  wire logic                              bus_level_pending,
  input  wire logic                              core_irq_ack,
  input  wire logic                              core_irq_return,
  output logic                                   core_irq_req,
  output logic                                   core_irq_high,
  output logic [3:0]                             core_irq_source,
  output logic [irq_regs_pkg::N_SRC-1:0]         gated_requests
);
  import irq_regs_pkg::*;

  state_t q;
  state_t d;

  irq_select_if #(.N(N_SRC)) sel ();

  irq_source_chooser #(.N(N_SRC)) u_chooser (
    .sel (sel.chooser)
  );

  // byte merge honouring the writable bits only
  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] wr_m);
    merge8 = (old_v & ~wr_m) | (new_v & wr_m);
  endfunction : merge8

  function automatic logic [31:0] widen8(input logic [7:0] v);
    widen8 = {24'h000000, v};
  endfunction : widen8

  // the six mapped register indices
  function automatic logic reg_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      PRIMARY_IRQ_MASK_IDX,
      PRIMARY_IRQ_RANK_IDX,
      USB_IRQ_MASK_IDX,
      BUS_LEVEL_IRQ_MASK_IDX,
      USB_IRQ_RANK_IDX,
      BUS_LEVEL_IRQ_RANK_IDX: reg_mapped = 1'b1;
      default:                reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  // active low pin level, taken only once stages two and three agree
  function automatic logic pin_level(input logic [2:0] stages, input logic held);
    if (stages[1] == stages[2]) begin
      pin_level = !stages[2];
    end else begin
      pin_level = held;
    end
  endfunction : pin_level

  logic [N_SRC-1:0] pend_vec;
  logic [N_SRC-1:0] en_vec;
  logic [N_SRC-1:0] rank_vec;
  logic [N_SRC-1:0] gated_now;
  logic             gate_on;

  always_comb begin
    pend_vec                = '0;
    pend_vec[SRC_EXT_A]     = q.ext_a_lvl;
    pend_vec[SRC_TIMER_A]   = timer_a_overflow_flag;
    pend_vec[SRC_EXT_B]     = q.ext_b_lvl;
    pend_vec[SRC_TIMER_B]   = timer_b_overflow_flag;
    pend_vec[SRC_SERIAL]    = serial_pending;
    pend_vec[SRC_USB]       = usb_pending;
    pend_vec[SRC_BUS_LEVEL] = bus_level_pending;

    en_vec                  = '0;
    en_vec[SRC_EXT_A]       = q.prim_mask[EXT_A_IRQ_POS];
    en_vec[SRC_TIMER_A]     = q.prim_mask[TIMER_A_IRQ_POS];
    en_vec[SRC_EXT_B]       = q.prim_mask[EXT_B_IRQ_POS];
    en_vec[SRC_TIMER_B]     = q.prim_mask[TIMER_B_IRQ_POS];
    en_vec[SRC_SERIAL]      = q.prim_mask[SERIAL_IRQ_POS];
    en_vec[SRC_USB]         = q.usb_mask[USB_IRQ_BIT_POS];
    en_vec[SRC_BUS_LEVEL]   = q.bus_mask[BUS_LEVEL_IRQ_BIT_POS];

    rank_vec                = '0;
    rank_vec[SRC_EXT_A]     = q.prim_rank[EXT_A_IRQ_POS];
    rank_vec[SRC_TIMER_A]   = q.prim_rank[TIMER_A_IRQ_POS];
    rank_vec[SRC_EXT_B]     = q.prim_rank[EXT_B_IRQ_POS];
    rank_vec[SRC_TIMER_B]   = q.prim_rank[TIMER_B_IRQ_POS];
    rank_vec[SRC_SERIAL]    = q.prim_rank[SERIAL_IRQ_POS];
    rank_vec[SRC_USB]       = q.usb_rank[USB_IRQ_BIT_POS];
    rank_vec[SRC_BUS_LEVEL] = q.bus_rank[BUS_LEVEL_IRQ_BIT_POS];

    gate_on   = q.prim_mask[GLOBAL_IRQ_GATE_POS];
    gated_now = pend_vec & en_vec & {N_SRC{gate_on}};
  end

  assign sel.pend       = gated_now;
  assign sel.rank       = rank_vec;
  assign sel.allow_low  = !q.low_active && !q.high_active;
  assign sel.allow_high = !q.high_active;

  // handshake strobes of this cycle
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic b_done;
  logic ar_take;
  logic r_done;
  logic ack_take;

  always_comb begin
    aw_take   = s_axi_awvalid && q.aw_rdy;
    w_take    = s_axi_wvalid && q.w_rdy;
    wr_commit = !q.aw_rdy && !q.w_rdy && !q.bvalid;
    b_done    = q.bvalid && s_axi_bready;
    ar_take   = s_axi_arvalid && q.ar_rdy;
    r_done    = q.rvalid && s_axi_rready;
    ack_take  = core_irq_ack && q.req_valid;
  end

  logic [7:0]       rd_byte;
  logic             rd_hit;
  logic [IDX_W-1:0] ar_idx;

  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_hit  = reg_mapped(ar_idx);
    rd_byte = 8'h00;
    case (ar_idx)
      PRIMARY_IRQ_MASK_IDX: begin
        rd_byte = q.prim_mask & PRIMARY_MASK_WR;
      end
      PRIMARY_IRQ_RANK_IDX: begin
        rd_byte = (q.prim_rank & PRIMARY_RANK_WR) | PRIMARY_RANK_RO;
      end
      USB_IRQ_MASK_IDX: begin
        rd_byte = q.usb_mask & USB_WR;
      end
      USB_IRQ_RANK_IDX: begin
        rd_byte = q.usb_rank & USB_WR;
      end
      BUS_LEVEL_IRQ_MASK_IDX: begin
        rd_byte = q.bus_mask & BUS_LEVEL_WR;
      end
      BUS_LEVEL_IRQ_RANK_IDX: begin
        rd_byte = q.bus_rank & BUS_LEVEL_WR;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_comb begin
    d = q;

    // write address and data taken in either order
    if (aw_take) begin
      d.aw_rdy = 1'b0;
      d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (w_take) begin
      d.w_rdy   = 1'b0;
      d.w_byte  = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end

    if (wr_commit) begin
      d.bvalid = 1'b1;
      d.bresp  = reg_mapped(q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      case (q.aw_idx)
        PRIMARY_IRQ_MASK_IDX: begin
          if (q.w_lane0) begin
            d.prim_mask = merge8(q.prim_mask, q.w_byte, PRIMARY_MASK_WR);
          end
        end
        PRIMARY_IRQ_RANK_IDX: begin
          if (q.w_lane0) begin
            d.prim_rank = merge8(q.prim_rank, q.w_byte, PRIMARY_RANK_WR);
          end
        end
        USB_IRQ_MASK_IDX: begin
          if (q.w_lane0) begin
            d.usb_mask = merge8(q.usb_mask, q.w_byte, USB_WR);
          end
        end
        USB_IRQ_RANK_IDX: begin
          if (q.w_lane0) begin
            d.usb_rank = merge8(q.usb_rank, q.w_byte, USB_WR);
          end
        end
        BUS_LEVEL_IRQ_MASK_IDX: begin
          if (q.w_lane0) begin
            d.bus_mask = merge8(q.bus_mask, q.w_byte, BUS_LEVEL_WR);
          end
        end
        BUS_LEVEL_IRQ_RANK_IDX: begin
          if (q.w_lane0) begin
            d.bus_rank = merge8(q.bus_rank, q.w_byte, BUS_LEVEL_WR);
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    if (b_done) begin
      d.bvalid = 1'b0;
      d.aw_rdy = 1'b1;
      d.w_rdy  = 1'b1;
    end

    // read channel, one outstanding
    if (ar_take) begin
      d.ar_rdy = 1'b0;
      d.rvalid = 1'b1;
      d.rdata  = widen8(rd_byte);
      d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_done) begin
      d.rvalid = 1'b0;
      d.ar_rdy = 1'b1;
    end

    // external pins: change accepted once stages two and three agree
    d.sync_a = {q.sync_a[1:0], ext_a_request_input_n};
    d.sync_b = {q.sync_b[1:0], ext_b_request_input_n};
    d.ext_a_lvl = pin_level(q.sync_a, q.ext_a_lvl);
    d.ext_b_lvl = pin_level(q.sync_b, q.ext_b_lvl);

    // handler nesting as seen from acknowledge and return
    if (core_irq_return) begin
      if (q.high_active) begin
        d.high_active = 1'b0;
      end else begin
        d.low_active = 1'b0;
      end
    end
    if (ack_take) begin
      if (q.req_high) begin
        d.high_active = 1'b1;
      end else begin
        d.low_active = 1'b1;
      end
    end

    d.gated      = gated_now;
    d.req_valid  = sel.valid && !ack_take;
    d.req_high   = sel.high;
    d.req_source = src_code(sel.slot);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.prim_mask   <= PRIMARY_IRQ_MASK_RST;
      q.prim_rank   <= PRIMARY_IRQ_RANK_RST;
      q.usb_mask    <= USB_IRQ_MASK_RST;
      q.bus_mask    <= BUS_LEVEL_IRQ_MASK_RST;
      q.usb_rank    <= USB_IRQ_RANK_RST;
      q.bus_rank    <= BUS_LEVEL_IRQ_RANK_RST;
      q.aw_rdy      <= 1'b1;
      q.w_rdy       <= 1'b1;
      q.ar_rdy      <= 1'b1;
      q.sync_a      <= 3'h7;
      q.sync_b      <= 3'h7;
      q.aw_idx      <= '0;
      q.w_byte      <= 8'h00;
      q.w_lane0     <= 1'b0;
      q.bvalid      <= 1'b0;
      q.bresp       <= RESP_OKAY;
      q.rvalid      <= 1'b0;
      q.rdata       <= 32'h0;
      q.rresp       <= RESP_OKAY;
      q.ext_a_lvl   <= 1'b0;
      q.ext_b_lvl   <= 1'b0;
      q.low_active  <= 1'b0;
      q.high_active <= 1'b0;
      q.req_valid   <= 1'b0;
      q.req_high    <= 1'b0;
      q.req_source  <= 4'h0;
      q.gated       <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready   = q.aw_rdy;
  assign s_axi_wready    = q.w_rdy;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.ar_rdy;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign core_irq_req    = q.req_valid;
  assign core_irq_high   = q.req_high;
  assign core_irq_source = q.req_source;
  assign gated_requests  = q.gated;

endmodule : irq_enable_rank_regs

// file: design/irq_regs_pkg.sv
// constants and state layout of the interrupt enable and priority register set
package irq_regs_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned IDX_W   = 10;
  localparam int unsigned N_SRC   = 7;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] PRIMARY_IRQ_MASK_IDX   = 10'h0a8;
  localparam logic [IDX_W-1:0] PRIMARY_IRQ_RANK_IDX   = 10'h0b8;
  localparam logic [IDX_W-1:0] USB_IRQ_MASK_IDX       = 10'h0e6;
  localparam logic [IDX_W-1:0] BUS_LEVEL_IRQ_MASK_IDX = 10'h0e7;
  localparam logic [IDX_W-1:0] USB_IRQ_RANK_IDX       = 10'h0f6;
  localparam logic [IDX_W-1:0] BUS_LEVEL_IRQ_RANK_IDX = 10'h0f7;

  // values after reset
  localparam logic [7:0] PRIMARY_IRQ_MASK_RST   = 8'h00;
  localparam logic [7:0] PRIMARY_IRQ_RANK_RST   = 8'h80;
  localparam logic [7:0] USB_IRQ_MASK_RST       = 8'h00;
  localparam logic [7:0] BUS_LEVEL_IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] USB_IRQ_RANK_RST       = 8'h00;
  localparam logic [7:0] BUS_LEVEL_IRQ_RANK_RST = 8'h00;

  // writable bits and constant read bits
  localparam logic [7:0] PRIMARY_MASK_WR = 8'h9f;
  localparam logic [7:0] PRIMARY_RANK_WR = 8'h1f;
  localparam logic [7:0] PRIMARY_RANK_RO = 8'h80;
  localparam logic [7:0] USB_WR          = 8'h02;
  localparam logic [7:0] BUS_LEVEL_WR    = 8'h01;

  // field positions
  localparam int unsigned GLOBAL_IRQ_GATE_POS        = 7;
  localparam int unsigned SERIAL_IRQ_POS             = 4;
  localparam int unsigned TIMER_B_IRQ_POS            = 3;
  localparam int unsigned EXT_B_IRQ_POS              = 2;
  localparam int unsigned TIMER_A_IRQ_POS            = 1;
  localparam int unsigned EXT_A_IRQ_POS              = 0;
  localparam int unsigned USB_IRQ_BIT_POS            = 1;
  localparam int unsigned BUS_LEVEL_IRQ_BIT_POS      = 0;

  // source slots in fixed arbitration order, slot 0 wins
  localparam int unsigned SRC_EXT_A     = 0;
  localparam int unsigned SRC_TIMER_A   = 1;
  localparam int unsigned SRC_EXT_B     = 2;
  localparam int unsigned SRC_TIMER_B   = 3;
  localparam int unsigned SRC_SERIAL    = 4;
  localparam int unsigned SRC_USB       = 5;
  localparam int unsigned SRC_BUS_LEVEL = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // source number shown to the core for each slot
  function automatic logic [3:0] src_code(input logic [2:0] slot);
    case (slot)
      3'h0:    src_code = 4'h0;
      3'h1:    src_code = 4'h1;
      3'h2:    src_code = 4'h2;
      3'h3:    src_code = 4'h3;
      3'h4:    src_code = 4'h4;
      3'h5:    src_code = 4'h8;
      3'h6:    src_code = 4'hf;
      default: src_code = 4'h0;
    endcase
  endfunction : src_code

  typedef struct packed {
    logic [7:0]       prim_mask;
    logic [7:0]       prim_rank;
    logic [7:0]       usb_mask;
    logic [7:0]       bus_mask;
    logic [7:0]       usb_rank;
    logic [7:0]       bus_rank;
    logic             aw_rdy;
    logic             w_rdy;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             ar_rdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [2:0]       sync_a;
    logic [2:0]       sync_b;
    logic             ext_a_lvl;
    logic             ext_b_lvl;
    logic             low_active;
    logic             high_active;
    logic             req_valid;
    logic             req_high;
    logic [3:0]       req_source;
    logic [N_SRC-1:0] gated;
  } state_t;

endpackage : irq_regs_pkg

// file: design/irq_select_if.sv
// selection signals between the register set and its source chooser
`timescale 1ns/1ps
interface irq_select_if #(parameter int unsigned N = 7);
  logic [N-1:0] pend;
  logic [N-1:0] rank;
  logic         allow_low;
  logic         allow_high;
  logic         valid;
  logic         high;
  logic [2:0]   slot;

  modport chooser (input pend, rank, allow_low, allow_high, output valid, high, slot);
  modport owner   (output pend, rank, allow_low, allow_high, input valid, high, slot);
endinterface : irq_select_if

// file: design/irq_source_chooser.sv
// picks one gated request by priority level, then by fixed slot order
`timescale 1ns/1ps
module irq_source_chooser #(
  parameter int unsigned N = 7
) (
  irq_select_if.chooser sel
);
  always_comb begin
    sel.valid = 1'b0;
    sel.high  = 1'b0;
    sel.slot  = 3'h0;
    // high level searched last so it overrides low, lowest slot wins
    for (int i = int'(N) - 1; i >= 0; i--) begin
      if (sel.pend[i] && !sel.rank[i] && sel.allow_low) begin
        sel.valid = 1'b1;
        sel.high  = 1'b0;
        sel.slot  = 3'(i);
      end
    end
    for (int i = int'(N) - 1; i >= 0; i--) begin
      if (sel.pend[i] && sel.rank[i] && sel.allow_high) begin
        sel.valid = 1'b1;
        sel.high  = 1'b1;
        sel.slot  = 3'(i);
      end
    end
  end
endmodule : irq_source_chooser

// file: sim/interrupt_enable_priority_regs_test.sv
// self-checking bench for the interrupt enable and priority registers
`timescale 1ns/1ps
module interrupt_enable_priority_regs_test;
  import irq_regs_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ext_a_request_input_n, ext_b_request_input_n;
  logic        timer_a_overflow_flag, timer_b_overflow_flag, serial_pending, usb_pending;
  logic        bus_level_pending, core_irq_ack, core_irq_return, core_irq_req, core_irq_high;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb, core_irq_source;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [6:0]  gated_requests, pend_set;
  logic        ack_go, ret_go;
  logic [23:0] v;
  int          fails, n_checks;
  logic [3:0]  code [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hf};
  logic [11:0] adr [6] = '{{PRIMARY_IRQ_MASK_IDX, 2'b00}, {PRIMARY_IRQ_RANK_IDX, 2'b00},
    {USB_IRQ_MASK_IDX, 2'b00}, {BUS_LEVEL_IRQ_MASK_IDX, 2'b00},
    {USB_IRQ_RANK_IDX, 2'b00}, {BUS_LEVEL_IRQ_RANK_IDX, 2'b00}};
  logic [7:0]  rstv [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  onev [6] = '{8'h9f, 8'h9f, 8'h02, 8'h01, 8'h02, 8'h01};

  irq_enable_rank_regs irq_enable_rank_regs_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_a_request_input_n, .ext_b_request_input_n, .timer_a_overflow_flag,
    .timer_b_overflow_flag, .serial_pending, .usb_pending, .bus_level_pending,
    .core_irq_ack, .core_irq_return, .core_irq_req, .core_irq_high, .core_irq_source,
    .gated_requests);
  irq_core_model irq_core_model_inst (.aclk, .pend_set, .ack_go, .ret_go, .ext_a_request_input_n,
    .ext_b_request_input_n, .timer_a_overflow_flag, .timer_b_overflow_flag,
    .serial_pending, .usb_pending, .bus_level_pending, .core_irq_ack, .core_irq_return);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // mask or rank of primary, usb and bus level registers
  task automatic set3(input bit rank, input logic [7:0] p, input logic [7:0] u,
                      input logic [7:0] b);
    wr(adr[rank ? 1 : 0], p);
    wr(adr[rank ? 4 : 2], u);
    wr(adr[rank ? 5 : 3], b);
  endtask : set3

  task automatic settle();
    repeat (6) @(posedge aclk);
    #1;
  endtask : settle

  // commands to the far-side model, applied there one edge later
  task automatic set_pend(input logic [6:0] p);
    @(posedge aclk);
    pend_set <= p;
  endtask : set_pend

  task automatic pulse(input bit ret);
    @(posedge aclk);
    ack_go <= !ret;
    ret_go <= ret;
    @(posedge aclk);
    ack_go <= 1'b0;
    ret_go <= 1'b0;
  endtask : pulse

  // primary, usb, bus level bit of one source slot
  function automatic logic [23:0] sel(input int i);
    return {(i < 5) ? 8'h01 << i : 8'h00, (i == 5) ? 8'h02 : 8'h00, (i == 6) ? 8'h01 : 8'h00};
  endfunction : sel

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    pend_set = 7'h00;
    {ack_go, ret_go} = 2'b00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adr[k]) begin
      rd(adr[k]);
      chk(rd_d, {24'h0, rstv[k]});
      wr(adr[k], 8'hff);
      rd(adr[k]);
      chk(rd_d, {24'h0, onev[k]});
      wr(adr[k], 8'h00);
      rd(adr[k]);
      chk(rd_d, {24'h0, rstv[k]});
    end
    s_axi_wstrb <= 4'h0;
    wr(adr[0], 8'hff);
    chk(resp, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rd(adr[0]);
    chk(rd_d, 32'h0);
    wr(12'h000, 8'hff);
    chk(resp, RESP_SLVERR);
    rd(12'h000);
    chk(rd_d, 32'h0);
    chk(resp, RESP_SLVERR);
    $display("registers done");
    set_pend(7'h7f);
    for (int i = 0; i < 7; i++) begin
      v = sel(i);
      set3(1'b0, 8'h80 | v[23:16], v[15:8], v[7:0]);
      settle();
      chk(gated_requests, 32'h1 << i);
      chk({core_irq_req, core_irq_source}, {1'b1, code[i]});
      set3(1'b0, v[23:16], v[15:8], v[7:0]);
      settle();
      chk({core_irq_req, gated_requests}, 0);
    end
    $display("gating done");
    set3(1'b0, 8'h9f, 8'h02, 8'h01);
    for (int i = 0; i < 7; i++) begin
      v = sel(i);
      set3(1'b1, v[23:16], v[15:8], v[7:0]);
      settle();
      chk({core_irq_high, core_irq_source}, {1'b1, code[i]});
    end
    set3(1'b1, 8'h00, 8'h00, 8'h00);
    settle();
    chk({core_irq_high, core_irq_source}, 5'h00);
    $display("ranking done");
    set_pend(7'h02);
    settle();
    chk(core_irq_req, 1);
    pulse(1'b0);
    set_pend(7'h0a);
    settle();
    chk(core_irq_req, 0);
    wr(adr[1], 8'h08);
    settle();
    chk({core_irq_req, core_irq_high, core_irq_source}, 6'h33);
    pulse(1'b0);
    set_pend(7'h4a);
    wr(adr[5], 8'h01);
    settle();
    chk(core_irq_req, 0);
    pulse(1'b1);
    settle();
    chk({core_irq_req, core_irq_high, core_irq_source}, 6'h33);
    $display("nesting done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(adr[0]);
    chk(rd_d, 32'h0);
    settle();
    chk({core_irq_req, gated_requests}, 0);
    $display("second reset done");
    finish_test();
  end
endmodule : interrupt_enable_priority_regs_test

// file: sim/irq_core_model.sv
// pending flag sources and core handler sequencer model
`timescale 1ns/1ps
module irq_core_model (
  input  wire logic       aclk,
  input  wire logic [6:0] pend_set,
  input  wire logic       ack_go,
  input  wire logic       ret_go,
  output logic            ext_a_request_input_n,
  output logic            ext_b_request_input_n,
  output logic            timer_a_overflow_flag,
  output logic            timer_b_overflow_flag,
  output logic            serial_pending,
  output logic            usb_pending,
  output logic            bus_level_pending,
  output logic            core_irq_ack,
  output logic            core_irq_return
);
  logic [6:0] pend_q;

  // flags and core pulses follow the bench commands one edge later
  always_ff @(posedge aclk) begin
    pend_q          <= pend_set;
    core_irq_ack    <= ack_go;
    core_irq_return <= ret_go;
  end
  // external pins are active low, idle high
  assign ext_a_request_input_n = ~pend_q[0];
  assign timer_a_overflow_flag = pend_q[1];
  assign ext_b_request_input_n = ~pend_q[2];
  assign timer_b_overflow_flag = pend_q[3];
  assign serial_pending        = pend_q[4];
  assign usb_pending           = pend_q[5];
  assign bus_level_pending     = pend_q[6];
endmodule : irq_core_model

// file: sim/irq_rank_properties.sv
// concurrent checks on the interrupt register set ports
`timescale 1ns/1ps
module irq_rank_properties
  import irq_regs_pkg::*;
(
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic [irq_regs_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                        timer_a_overflow_flag,
  input wire logic                        timer_b_overflow_flag,
  input wire logic                        serial_pending,
  input wire logic                        usb_pending,
  input wire logic                        bus_level_pending,
  input wire logic                        core_irq_ack,
  input wire logic                        core_irq_req,
  input wire logic                        core_irq_high,
  input wire logic [3:0]                  core_irq_source,
  input wire logic [irq_regs_pkg::N_SRC-1:0] gated_requests
);
  import irq_regs_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic int slot_of(input logic [3:0] c);
    return (c == 4'h8) ? 5 : ((c == 4'hf) ? 6 : int'(c));
  endfunction : slot_of

  a_timer_a_gate: assert property (gated_requests[1] |-> $past(timer_a_overflow_flag))
    else $error("timer a gated without its flag");
  a_timer_b_gate: assert property (gated_requests[3] |-> $past(timer_b_overflow_flag))
    else $error("timer b gated without its flag");
  a_serial_gate: assert property (gated_requests[4] |-> $past(serial_pending))
    else $error("serial gated without pending");
  a_usb_gate: assert property (gated_requests[5] |-> $past(usb_pending))
    else $error("usb gated without pending");
  a_bus_gate: assert property (gated_requests[6] |-> $past(bus_level_pending))
    else $error("bus level gated without pending");
  a_source_is_gated: assert property (core_irq_req |-> gated_requests[slot_of(core_irq_source)])
    else $error("request names a source that is not gated");
  a_idle_no_req: assert property (gated_requests == '0 |-> !core_irq_req)
    else $error("request with nothing gated");
  a_ack_drops_req: assert property (core_irq_ack && core_irq_req |=> !core_irq_req)
    else $error("request stayed up after accepted ack");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");

  c_high_req: cover property (core_irq_req && core_irq_high);
  c_ack_taken: cover property (core_irq_ack && core_irq_req);
  c_bus_gated: cover property (gated_requests[6]);
endmodule : irq_rank_properties

bind irq_enable_rank_regs irq_rank_properties irq_rank_properties_inst (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .timer_a_overflow_flag,
  .timer_b_overflow_flag, .serial_pending, .usb_pending, .bus_level_pending, .core_irq_ack,
  .core_irq_req, .core_irq_high, .core_irq_source, .gated_requests);
